// ===== src/tsmp_params.svh
// constants of the phy-side port of the tri-speed mac
`ifndef TSMP_PARAMS_SVH
`define TSMP_PARAMS_SVH

// data widths and word field positions
`define TSMP_BYTE_W        8
`define TSMP_NIB_W         4
`define TSMP_TXW_LAST      8
`define TSMP_TXW_ERR       9
`define TSMP_TXW_W         10
`define TSMP_RXW_LAST      8
`define TSMP_RXW_W         9

// buffer depth, link-side gap between frames in link cycles
`define TSMP_BUF_DEPTH     2
`define TSMP_IFG_CYC       12
`define TSMP_IFG_W         4

// clock rates in kHz
`define TSMP_CORE_CLK_KHZ  10000
`define TSMP_TXCLK_GIG_KHZ 125000
`define TSMP_TXCLK_100_KHZ 12500
`define TSMP_TXCLK_10_KHZ  1250

// reset values of the pins
`define TSMP_RST_BYTE      8'h00
`define TSMP_RST_NIB       4'h0

`endif

// ===== src/tsmp_pkg.sv
// types of the phy-side port of the tri-speed mac
package tsmp_pkg;

   typedef enum logic [1:0]
   {
      tx_idle  = 2'b00,
      tx_frame = 2'b01,
      tx_gap   = 2'b10
   } tsmp_tx_state_e;

   typedef logic [7:0] tsmp_byte_t;
   typedef logic [3:0] tsmp_nib_t;

endpackage

// ===== src/tsmp_buf.sv
// small dual-clock buffer with gray-coded pointers
`timescale 1ns/1ps
module tsmp_buf #(
   parameter int W     = 10,
   parameter int DEPTH = 2
) (
   // write side
   input  wire logic         wclk,
   input  wire logic         wrst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // read side
   input  wire logic         rclk,
   input  wire logic         rrst_n,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wbin_q, wgray_q, rbin_q, rgray_q;
   logic [AW:0]  rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;

   function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
      logic [AW:0] b;
      b = '0;
      for (int i = AW; i >= 0; i--)
      begin
         b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
      end
      return b;
   endfunction

   wire         push    = in_valid & in_ready;
   wire         pop     = out_valid & out_ready;
   wire [AW:0]  wbin_d  = wbin_q + {{AW{1'b0}}, push};
   wire [AW:0]  rbin_d  = rbin_q + {{AW{1'b0}}, pop};
   wire [AW:0]  rbin_w  = gray2bin(rg_s2_q);
   wire [AW:0]  wbin_r  = gray2bin(wg_s2_q);
   wire [AW:0]  fill_w  = wbin_q - rbin_w;

   assign in_ready  = (fill_w != DEPTH[AW:0]);
   assign out_valid = (rbin_q != wbin_r);
   assign out_data  = mem_q[rbin_q[AW-1:0]];

   // write domain
   always_ff @(posedge wclk or negedge wrst_n)
   begin
      if (!wrst_n)
      begin
         wbin_q  <= '0;
         wgray_q <= '0;
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end
      else
      begin
         wbin_q  <= wbin_d;
         wgray_q <= wbin_d ^ (wbin_d >> 1);
         rg_s1_q <= rgray_q;
         rg_s2_q <= rg_s1_q;
      end
   end

   always_ff @(posedge wclk)
   begin
      if (push)
         mem_q[wbin_q[AW-1:0]] <= in_data;
   end

   // read domain
   always_ff @(posedge rclk or negedge rrst_n)
   begin
      if (!rrst_n)
      begin
         rbin_q  <= '0;
         rgray_q <= '0;
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end
      else
      begin
         rbin_q  <= rbin_d;
         rgray_q <= rbin_d ^ (rbin_d >> 1);
         wg_s1_q <= wgray_q;
         wg_s2_q <= wg_s1_q;
      end
   end

endmodule // tsmp_buf

// ===== src/tsmp_port.sv
// phy-side g/mii port of a tri-speed ethernet mac
//
// Function
// - management output enable high exactly while the output bit is valid
// - gigabit: upper byte nibble goes on rising-edge group bits 7 to 4
// - 10/100: upper four rising-edge group bits carry no meaning
// - external ddr cells build the wire nibble from both low groups
// - gigabit: rising-edge low nibble equals falling-edge nibble every cycle
// - 10/100: high nibble on rising group, low nibble on falling group
// - transmit clock is 125, 12.5 or 1.25 MHz by speed
// - gmii option: transmit data leave as one 8-bit bus
// - transmit enable high exactly on cycles carrying frame data
// - transmit error asserted on every deliberately corrupted byte
// - receive inputs captured externally on rising and falling receive edges
// - receive inputs pass a link-clocked pipeline before the core
// - split receive valids only in ddr option; gmii uses single valid
`timescale 1ns/1ps
`include "tsmp_params.svh"
module tsmp_port (
   // core clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // static configuration
   input  wire logic        cfg_gig,
   input  wire logic        cfg_gmii,
   // transmit stream from the mac
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_last,
   input  wire logic        tx_err,
   // receive stream to the mac
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [7:0]       rx_data,
   output logic             rx_last,
   // management bit stream
   input  wire logic        mgmt_out_bit,
   input  wire logic        mgmt_out_valid,
   output logic             mgmt_in_bit,
   // link clock
   input  wire logic        link_clk,
   // transmit pins
   output logic [7:0]       txd_pos,
   output logic [3:0]       txd_neg,
   output logic [7:0]       txd,
   output logic             txen,
   output logic             txer,
   // receive pins
   input  wire logic        rxdv_pos,
   input  wire logic        rxdv_neg,
   input  wire logic [7:0]  rxd_pos,
   input  wire logic [3:0]  rxd_neg,
   input  wire logic        rxdv,
   input  wire logic [7:0]  rxd,
   // management pin
   input  wire logic        md_in,
   output logic             md_out,
   output logic             md_oe
);
   // transmit clock rates per speed, for the clock plan outside
   localparam int TXCLK_GIG_KHZ = `TSMP_TXCLK_GIG_KHZ;
   localparam int TXCLK_100_KHZ = `TSMP_TXCLK_100_KHZ;
   localparam int TXCLK_10_KHZ  = `TSMP_TXCLK_10_KHZ;
   localparam int IFG_CYC       = `TSMP_IFG_CYC;

   // ---------------------------------------------------------------
   // link-side reset, released on the link clock
   logic lrst_s1_q;
   logic lrst_n_q;

   always_ff @(posedge link_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lrst_s1_q <= 1'b0;
         lrst_n_q  <= 1'b0;
      end
      else
      begin
         lrst_s1_q <= 1'b1;
         lrst_n_q  <= lrst_s1_q;
      end
   end

   // configuration levels into the link domain
   logic gig_s1_q, gig_l_q;
   logic gmii_s1_q, gmii_l_q;

   always_ff @(posedge link_clk or negedge lrst_n_q)
   begin
      if (!lrst_n_q)
      begin
         gig_s1_q  <= 1'b0;
         gig_l_q   <= 1'b0;
         gmii_s1_q <= 1'b0;
         gmii_l_q  <= 1'b0;
      end
      else
      begin
         gig_s1_q  <= cfg_gig;
         gig_l_q   <= gig_s1_q;
         gmii_s1_q <= cfg_gmii;
         gmii_l_q  <= gmii_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // transmit path: core stream into the link domain
   logic                    tw_valid;
   logic [`TSMP_TXW_W-1:0]  tw_data;
   logic                    tw_ready;

   tsmp_buf #(
      .W     (`TSMP_TXW_W),
      .DEPTH (`TSMP_BUF_DEPTH)
   ) u_tx_buf (
      .wclk      (clock),
      .wrst_n    (arst_n),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   ({tx_err, tx_last, tx_data}),
      .rclk      (link_clk),
      .rrst_n    (lrst_n_q),
      .out_valid (tw_valid),
      .out_ready (tw_ready),
      .out_data  (tw_data)
   );

   tsmp_pkg::tsmp_tx_state_e tx_st_q, tx_st_d;
   logic [`TSMP_IFG_W-1:0]   gap_q, gap_d;
   tsmp_pkg::tsmp_byte_t     tx_byte_q, tx_byte_d;
   logic                     txen_d, txer_d;

   // the gap after a frame stalls the buffer, so the core sees back-pressure
   assign tw_ready = (tx_st_q != tsmp_pkg::tx_gap);

   wire tw_take = tw_valid & tw_ready;
   wire tw_last = tw_data[`TSMP_TXW_LAST];
   wire tw_err  = tw_data[`TSMP_TXW_ERR];

   always_comb
   begin
      tx_st_d   = tx_st_q;
      gap_d     = gap_q;
      tx_byte_d = tx_byte_q;
      txen_d    = 1'b0;
      txer_d    = 1'b0;
      unique case (tx_st_q)
         tsmp_pkg::tx_idle:
         begin
            if (tw_take)
            begin
               tx_byte_d = tw_data[7:0];
               txen_d    = 1'b1;
               txer_d    = tw_err;
               tx_st_d   = tw_last ? tsmp_pkg::tx_gap
                                   : tsmp_pkg::tx_frame;
               gap_d     = IFG_CYC[`TSMP_IFG_W-1:0];
            end
         end
         tsmp_pkg::tx_frame:
         begin
            txen_d = 1'b1;
            if (tw_take)
            begin
               tx_byte_d = tw_data[7:0];
               txer_d    = tw_err;
               if (tw_last)
               begin
                  tx_st_d = tsmp_pkg::tx_gap;
                  gap_d   = IFG_CYC[`TSMP_IFG_W-1:0];
               end
            end
            else
            begin
               // starved mid-frame: corrupt the byte on purpose
               txer_d = 1'b1;
            end
         end
         tsmp_pkg::tx_gap:
         begin
            gap_d = gap_q - 4'h1;
            if (gap_q == 4'h1)
               tx_st_d = tsmp_pkg::tx_idle;
         end
         default:
         begin
            tx_st_d = tsmp_pkg::tx_idle;
         end
      endcase
   end

   // pin mapping of the next byte
   wire [7:0] byte_on  = txen_d ? tx_byte_d : `TSMP_RST_BYTE;
   wire [7:0] pos_gig  = byte_on;
   wire [7:0] pos_slow = {`TSMP_RST_NIB, byte_on[7:4]};
   wire [7:0] txd_pos_d = gmii_l_q ? `TSMP_RST_BYTE
                        : (gig_l_q ? pos_gig : pos_slow);
   // low rising nibble and falling nibble feed the ddr cells
   wire [3:0] txd_neg_d = gmii_l_q ? `TSMP_RST_NIB : byte_on[3:0];
   wire [7:0] txd_d     = gmii_l_q ? byte_on : `TSMP_RST_BYTE;

   always_ff @(posedge link_clk or negedge lrst_n_q)
   begin
      if (!lrst_n_q)
      begin
         tx_st_q   <= tsmp_pkg::tx_idle;
         gap_q     <= '0;
         tx_byte_q <= `TSMP_RST_BYTE;
         txen      <= 1'b0;
         txer      <= 1'b0;
         txd_pos   <= `TSMP_RST_BYTE;
         txd_neg   <= `TSMP_RST_NIB;
         txd       <= `TSMP_RST_BYTE;
      end
      else
      begin
         tx_st_q   <= tx_st_d;
         gap_q     <= gap_d;
         tx_byte_q <= tx_byte_d;
         txen      <= txen_d;
         txer      <= txer_d;
         txd_pos   <= txd_pos_d;
         txd_neg   <= txd_neg_d;
         txd       <= txd_d;
      end
   end

   // ---------------------------------------------------------------
   // receive path: two pipeline stages on the link clock
   logic       dvp_1_q, dvn_1_q, dv_1_q, dvp_2_q, dvn_2_q, dv_2_q;
   logic [7:0] rdp_1_q, rd_1_q, rdp_2_q, rd_2_q;
   logic [3:0] rdn_1_q, rdn_2_q;

   always_ff @(posedge link_clk or negedge lrst_n_q)
   begin
      if (!lrst_n_q)
      begin
         {dvp_1_q, dvn_1_q, dv_1_q} <= 3'h0;
         {dvp_2_q, dvn_2_q, dv_2_q} <= 3'h0;
         {rdp_1_q, rd_1_q, rdn_1_q} <= 20'h00000;
         {rdp_2_q, rd_2_q, rdn_2_q} <= 20'h00000;
      end
      else
      begin
         {dvp_1_q, dvn_1_q, dv_1_q} <= {rxdv_pos, rxdv_neg, rxdv};
         {dvp_2_q, dvn_2_q, dv_2_q} <= {dvp_1_q, dvn_1_q, dv_1_q};
         {rdp_1_q, rd_1_q, rdn_1_q} <= {rxd_pos, rxd, rxd_neg};
         {rdp_2_q, rd_2_q, rdn_2_q} <= {rdp_1_q, rd_1_q, rdn_1_q};
      end
   end

   // split valids only for the ddr option
   wire       r_valid = gmii_l_q ? dv_2_q
                      : (gig_l_q ? dvp_2_q : (dvp_2_q & dvn_2_q));
   wire [7:0] r_byte  = gmii_l_q ? rd_2_q
                      : (gig_l_q ? rdp_2_q
                                 : {rdp_2_q[3:0], rdn_2_q});

   // hold one byte so its last flag is known when valid drops
   logic       hb_valid_q;
   logic [7:0] hb_q;

   always_ff @(posedge link_clk or negedge lrst_n_q)
   begin
      if (!lrst_n_q)
      begin
         hb_valid_q <= 1'b0;
         hb_q       <= `TSMP_RST_BYTE;
      end
      else
      begin
         hb_valid_q <= r_valid;
         hb_q       <= r_valid ? r_byte : hb_q;
      end
   end

   // the phy cannot be stalled: a full buffer drops the byte
   logic [`TSMP_RXW_W-1:0] rw_data;

   tsmp_buf #(
      .W     (`TSMP_RXW_W),
      .DEPTH (`TSMP_BUF_DEPTH)
   ) u_rx_buf (
      .wclk      (link_clk),
      .wrst_n    (lrst_n_q),
      .in_valid  (hb_valid_q),
      .in_ready  (),
      .in_data   ({~r_valid, hb_q}),
      .rclk      (clock),
      .rrst_n    (arst_n),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rw_data)
   );

   assign rx_data = rw_data[7:0];
   assign rx_last = rw_data[`TSMP_RXW_LAST];

   // ---------------------------------------------------------------
   // management pin, core domain
   logic md_s1_q;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         md_out      <= 1'b0;
         md_oe       <= 1'b0;
         md_s1_q     <= 1'b0;
         mgmt_in_bit <= 1'b0;
      end
      else
      begin
         md_out      <= mgmt_out_valid & mgmt_out_bit;
         md_oe       <= mgmt_out_valid;
         md_s1_q     <= md_in;
         mgmt_in_bit <= md_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // checks
   chk_mdo_enable: assert property (
      @(posedge clock) disable iff (!arst_n)
      mgmt_out_valid |=> md_oe && (md_out == $past(mgmt_out_bit)))
      else $error("management enable or bit wrong");

   chk_gig_upper: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (txen && gig_l_q && !gmii_l_q && $stable(gig_l_q))
         |-> (txd_pos[7:4] == tx_byte_q[7:4]))
      else $error("gigabit upper nibble wrong");

   chk_slow_upper: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (!gig_l_q && !$past(gig_l_q)) |-> (txd_pos[7:4] == 4'h0))
      else $error("unused upper bits not quiet");

   chk_gig_nibbles: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (gig_l_q && $past(gig_l_q) && !$past(gmii_l_q))
         |-> (txd_pos[3:0] == txd_neg))
      else $error("gigabit low nibbles differ");

   chk_slow_split: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (txen && !$past(gig_l_q) && !$past(gmii_l_q))
         |-> (txd_pos[3:0] == tx_byte_q[7:4])
             && (txd_neg == tx_byte_q[3:0]))
      else $error("10/100 nibble split wrong");

   chk_gmii_bus: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (txen && $past(gmii_l_q)) |-> (txd == tx_byte_q))
      else $error("gmii byte wrong");

   sequence seq_last_taken;
      tw_take && tw_last;
   endsequence

   sequence seq_quiet_gap;
      !txen [*8];
   endsequence

   chk_txen_frame: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      seq_last_taken |=> txen ##1 seq_quiet_gap)
      else $error("transmit enable wrong around frame end");

   chk_txer_code: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      ((tw_take && tw_err) || (tx_st_q == tsmp_pkg::tx_frame && !tw_take))
         |=> (txer && txen))
      else $error("transmit error not raised");

   chk_rx_select: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (gmii_l_q && $past(gmii_l_q) && !$past(rxdv, 3))
         |-> !hb_valid_q)
      else $error("receive valid source wrong");

   chk_rx_nibbles: assert property (
      @(posedge link_clk) disable iff (!lrst_n_q)
      (hb_valid_q && !$past(gig_l_q) && !$past(gmii_l_q))
         |-> (hb_q == {$past(rxd_pos[3:0], 3), $past(rxd_neg, 3)}))
      else $error("10/100 receive byte misbuilt");

endmodule // tsmp_port

// ===== verification/tsmp_phy_model.sv
// phy model: captures the transmit pins, drives receive and management pins
`timescale 1ns/1ps
module tsmp_phy_model (
   // link clock and mode
   input  wire logic       link_clk,
   input  wire logic       cfg_gig,
   input  wire logic       cfg_gmii,
   // transmit pins
   input  wire logic [7:0] txd_pos,
   input  wire logic [3:0] txd_neg,
   input  wire logic [7:0] txd,
   input  wire logic       txen,
   input  wire logic       txer,
   // receive pins
   output logic            rxdv_pos,
   output logic            rxdv_neg,
   output logic [7:0]      rxd_pos,
   output logic [3:0]      rxd_neg,
   output logic            rxdv,
   output logic [7:0]      rxd,
   // management pin
   output logic            md_drv,
   output logic            md_val
);
   logic [8:0] cap[$];
   int         frames = 0;
   int         ddr_bad = 0;
   logic       txen_q = 1'b0;

   initial
   begin
      {rxdv_pos, rxdv_neg, rxdv} = 3'h0;
      {rxd_pos, rxd_neg, rxd} = 20'h00000;
      {md_drv, md_val} = 2'h0;
   end

   // wire byte as the external ddr cells would form it
   always @(posedge link_clk)
   begin
      if (txen)
      begin
         if (cfg_gmii)
            cap.push_back({txer, txd});
         else if (cfg_gig)
            cap.push_back({txer, txd_pos});
         else
            cap.push_back({txer, txd_pos[3:0], txd_neg});
         if (!cfg_gmii && cfg_gig && txd_pos[3:0] !== txd_neg)
            ddr_bad++;
      end
      if (txen_q && !txen)
         frames++;
      txen_q <= txen;
   end

   // invalid cycles toggle data, unused option shows valid junk
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge link_clk);
         #5;
         rxdv = !cfg_gmii;
         {rxdv_pos, rxdv_neg} = {2{cfg_gmii}};
         {rxd_pos, rxd_neg, rxd} = ~{rxd_pos, rxd_neg, rxd};
      end
   endtask

   task automatic send(input logic [7:0] b0, input logic [7:0] b1);
      logic [7:0] b[2];
      b = '{b0, b1};
      foreach (b[i])
      begin
         @(posedge link_clk);
         #5;
         rxdv = cfg_gmii;
         {rxdv_pos, rxdv_neg} = {2{!cfg_gmii}};
         rxd = b[i];
         rxd_pos = cfg_gig ? b[i] : {~b[i][7:4], b[i][7:4]};
         rxd_neg = b[i][3:0];
      end
      idle(3);
   endtask
endmodule // tsmp_phy_model

// ===== verification/tb_top.sv
// testbench of the phy-side port
`timescale 1ns/1ps
module tb_top;
   logic       clock = 1'b0;
   logic       link_clk = 1'b0;
   logic       arst_n = 1'b0;
   logic       cfg_gig = 1'b0;
   logic       cfg_gmii = 1'b0;
   logic       tx_valid = 1'b0;
   logic       tx_last = 1'b0;
   logic       tx_err = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic       rx_ready = 1'b0;
   logic       mgmt_out_bit = 1'b0;
   logic       mgmt_out_valid = 1'b0;
   logic       tx_ready, rx_valid, rx_last, mgmt_in_bit, txen, txer;
   logic       rxdv_pos, rxdv_neg, rxdv, md_out, md_oe, md_drv, md_val;
   logic [7:0] rx_data, txd_pos, txd, rxd_pos, rxd;
   logic [3:0] txd_neg, rxd_neg;
   logic       md_wire;
   int         fail_count = 0;
   int         total_checks = 0;
   int         tx_stalls = 0;

   // shared management line with pull-up
   assign md_wire = md_oe ? md_out : (md_drv ? md_val : 1'b1);

   tsmp_port dut (
      .clock, .arst_n, .cfg_gig, .cfg_gmii, .tx_valid, .tx_ready,
      .tx_data, .tx_last, .tx_err, .rx_valid, .rx_ready, .rx_data,
      .rx_last, .mgmt_out_bit, .mgmt_out_valid, .mgmt_in_bit, .link_clk,
      .txd_pos, .txd_neg, .txd, .txen, .txer, .rxdv_pos, .rxdv_neg,
      .rxd_pos, .rxd_neg, .rxdv, .rxd, .md_in(md_wire), .md_out, .md_oe
   );

   tsmp_phy_model phy (
      .link_clk, .cfg_gig, .cfg_gmii, .txd_pos, .txd_neg, .txd, .txen,
      .txer, .rxdv_pos, .rxdv_neg, .rxd_pos, .rxd_neg, .rxdv, .rxd,
      .md_drv, .md_val
   );

   initial
   begin
      forever #50 clock = ~clock;
   end

   initial
   begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      #500000;
      fail_count++;
      report_and_stop();
   end

   task automatic chk(input string what, input logic [8:0] exp,
                      input logic [8:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask

   task automatic do_reset(input logic gig, input logic gmii);
      wait_clk(1);
      arst_n = 1'b0;
      {cfg_gig, cfg_gmii} = {gig, gmii};
      phy.idle(4);
      wait_clk(1);
      arst_n = 1'b1;
      wait_clk(6);
      phy.cap.delete();
      phy.frames = 0;
      phy.ddr_bad = 0;
   endtask

   // request held until ready is seen at a rising edge
   task automatic push(input logic [7:0] d, input logic l, input logic e);
      logic rdy;
      int   n;
      tx_valid = 1'b1;
      {tx_data, tx_last, tx_err} = {d, l, e};
      n = 0;
      do
      begin
         @(negedge clock);
         rdy = tx_ready;
         wait_clk(1);
         tx_stalls += (rdy !== 1'b1);
         n++;
      end
      while (rdy !== 1'b1 && n < 100);
   endtask

   // frames of 1, 2, 2 bytes back to back; gaps refill the buffer
   task automatic tx_test();
      logic [8:0] exp[5];
      int         n;
      exp = '{9'h0a5, 9'h03c, 9'h0c3, 9'h196, 9'h069};
      tx_stalls = 0;
      push(8'ha5, 1'b1, 1'b0);
      push(8'h3c, 1'b0, 1'b0);
      push(8'hc3, 1'b1, 1'b0);
      push(8'h96, 1'b0, 1'b1);
      push(8'h69, 1'b1, 1'b0);
      tx_valid = 1'b0;
      n = 0;
      while (phy.frames < 3 && n < 300)
      begin
         wait_clk(1);
         n++;
      end
      wait_clk(4);
      chk("tx frames", 9'h003, 9'(phy.frames));
      chk("tx bytes", 9'h005, 9'(phy.cap.size()));
      foreach (exp[i])
         chk("tx byte", exp[i], phy.cap[i]);
      chk("ddr nibbles", 9'h000, 9'(phy.ddr_bad));
      chk("tx refused", 9'h001, {8'h00, tx_stalls > 0});
   endtask

   // receiver stalls first; both bytes must survive
   task automatic rx_test(input logic [7:0] b0, input logic [7:0] b1);
      logic [8:0] got[$];
      int         n;
      phy.send(b0, b1);
      wait_clk(10);
      chk("rx held", 9'h001, {8'h00, rx_valid});
      rx_ready = 1'b1;
      n = 0;
      while (got.size() < 2 && n < 50)
      begin
         @(negedge clock);
         if (rx_valid === 1'b1)
            got.push_back({rx_last, rx_data});
         wait_clk(1);
         n++;
      end
      rx_ready = 1'b0;
      chk("rx byte 0", {1'b0, b0}, got[0]);
      chk("rx byte 1", {1'b1, b1}, got[1]);
      wait_clk(10);
      chk("rx extra", 9'h000, {8'h00, rx_valid});
   endtask

   task automatic mgmt_test();
      {mgmt_out_valid, mgmt_out_bit} = 2'h3;
      wait_clk(2);
      chk("md drive 1", 9'h003, {7'h00, md_oe, md_out});
      mgmt_out_bit = 1'b0;
      wait_clk(2);
      chk("md drive 0", 9'h002, {7'h00, md_oe, md_out});
      mgmt_out_valid = 1'b0;
      wait_clk(2);
      chk("md release", 9'h000, {7'h00, md_oe, md_out});
      {phy.md_drv, phy.md_val} = 2'h2;
      wait_clk(3);
      chk("md in 0", 9'h000, {8'h00, mgmt_in_bit});
      phy.md_drv = 1'b0;
      wait_clk(3);
      chk("md in 1", 9'h001, {8'h00, mgmt_in_bit});
   endtask

   initial
   begin
      logic [1:0] modes[3];
      modes = '{2'b11, 2'b10, 2'b00};
      foreach (modes[i])
      begin
         do_reset(modes[i][1], modes[i][0]);
         tx_test();
         rx_test(8'h5a, 8'he7);
         if (i == 0)
            mgmt_test();
      end
      report_and_stop();
   end
endmodule // tb_top
